// ---- core/ifd_decoder.sv ----
// ifd_decoder: splits program words into class and operand fields and
// paces each instruction over one or more four-clock instruction cycles.
// assumes program memory presents the next word while FETCH_REQ is high,
// and the datapath drives skip results and pointer region on CLK.
//
// Summary of operation
// - one 14-bit word, no extension words
// - classes byte, bit, literal/control
// - four clocks per cycle, default one cycle
// - both subroutine calls take two cycles
// - all three returns take two cycles
// - jumps and taken skips take two cycles
// - indirect access to program memory adds cycle
// - file operands are always read first
// - destination bit 0 accumulator, 1 file
// - file address bits 6..0, 0x00..0x7F
// - bit ops: opcode, bit number, address
// - general literal is bits 7..0
// - call and jump target bits 10..0
// - page latch literal bits 6..0
// - bank select literal is low five bits
// - relative jump offset is low nine bits
// - pointer offset: select bit 6, literal 5..0
// - pointer select picks pointer 0 or 1
// - pointer increment carries select and mode
// - redirect or taken skip: closing cycle nop
`timescale 1ns/10ps

module ifd_decoder
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // program memory side
  input wire logic [ifd_pkg::WORD_W-1:0] WORD_IN,
  output logic FETCH_REQ,
  // datapath status
  input wire logic TEST_TRUE,
  input wire logic [1:0] PTR_IN_PROG,
  // decoded instruction and pacing
  output ifd_pkg::ifd_dec_type DEC,
  output logic [1:0] PHASE,
  output logic [1:0] CYCLE_IDX,
  output logic EXEC_NOP
);
  import ifd_pkg::*;

  // match on the bits that matter only
  function automatic logic hit(input logic [13:0] w,
                               input logic [13:0] v,
                               input logic [13:0] m);
    hit = ((w & m) == v);
  endfunction

  // byte-class recognition, used by the decoder and by the pacing
  function automatic logic is_byte(input logic [13:0] w);
    logic lo;
    logic hi;
    lo = (w[13:12] == 2'h0) && (w[11:8] != 4'h0);
    hi = hit(w, V_HI_BYTE0, M_HI6) || hit(w, V_HI_BYTE1, M_HI6)
      || hit(w, V_HI_BYTE2, M_HI6) || hit(w, V_HI_BYTE3, M_HI6)
      || hit(w, V_HI_BYTE4, M_HI6);
    is_byte = lo || hi || hit(w, V_STORE_ACC, M_HI7);
  endfunction

  // whole-word decode into class, operation and operand fields
  // fields that a format does not carry stay zero, so a consumer never
  // sees stale operand bits from an earlier word
  function automatic ifd_dec_type decode(input logic [13:0] w);
    ifd_dec_type d;
    d = '0;
    d.word = w;
    d.op = OP_PLAIN;
    if (hit(w, V_BITCLS, M_HI2)) begin
      // bit class: opcode, bit number, file address
      d.cls = CLS_BIT;
      d.file_rmw = 1'b1;
      d.bitno = w[B_LSB +: B_W];
      d.faddr = w[F_LSB +: F_W];
      if (hit(w, V_SKIP_CLR, M_HI4) || hit(w, V_SKIP_SET, M_HI4)) begin
        d.op = OP_SKIP;
      end
    end else if (is_byte(w)) begin
      // byte class: opcode, destination bit, file address
      d.cls = CLS_BYTE;
      d.dest_file = w[D_POS];
      // clearing the accumulator names no file; its low bits are don't-care
      // and must neither show as an address nor add an indirect cycle
      if (!hit(w, V_CLR_ACC, M_HI12)) begin
        d.file_rmw = 1'b1;
        d.faddr = w[F_LSB +: F_W];
      end
      if (hit(w, V_DEC_SKIP, M_HI6) || hit(w, V_INC_SKIP, M_HI6)) begin
        d.op = OP_SKIP;
      end
    end else begin
      // literal and control class, narrowest opcode fields first
      d.cls = CLS_LITCTL;
      if (hit(w, V_CALL, M_HI3)) begin
        d.op = OP_CALL;
        d.k11 = w[K11_W-1:0];
      end else if (hit(w, V_ABS_JUMP, M_HI3)) begin
        d.op = OP_ABS_JUMP;
        d.k11 = w[K11_W-1:0];
      end else if (hit(w, V_REL_JUMP, M_HI5)) begin
        d.op = OP_REL_JUMP;
        d.k9 = w[K9_W-1:0];
      end else if (hit(w, V_LOAD_PAGE, M_HI7)) begin
        d.op = OP_LOAD_PAGE;
        d.k7 = w[K7_W-1:0];
      end else if (hit(w, V_PTROFS, M_HI7)) begin
        d.op = OP_PTROFS;
        d.ptr_sel = w[N_POS];
        d.k6 = w[K6_W-1:0];
      end else if (hit(w, V_LOAD_BANK, M_HI9)) begin
        d.op = OP_LOAD_BANK;
        d.k5 = w[K5_W-1:0];
      end else if (hit(w, V_PTRINC, M_HI11)) begin
        d.op = OP_PTRINC;
        d.ptr_sel = w[PTR_INC_N_POS];
        d.mode = w[MM_W-1:0];
      end else if (hit(w, V_REL_JUMP_ACC, M_ALL)) begin
        d.op = OP_REL_JUMP_ACC;
      end else if (hit(w, V_CALL_ACC, M_ALL)) begin
        d.op = OP_CALL_ACC;
      end else if (hit(w, V_INT_RET, M_ALL)) begin
        d.op = OP_INT_RET;
      end else if (hit(w, V_RETURN, M_ALL)) begin
        d.op = OP_RETURN;
      end else if (hit(w, V_ZERO, M_HI6)) begin
        d.op = OP_ONLY;
      end else begin
        // every other word of this class is a general eight-bit literal
        if (hit(w, V_RET_LIT, M_HI6)) begin
          d.op = OP_RET_LIT;
        end
        d.k8 = w[K8_W-1:0];
      end
    end
    decode = d;
  endfunction

  // whole state of the block
  typedef struct packed {
    logic [1:0] phase;
    logic [1:0] icyc;
    logic [1:0] total;
    logic redirect;
    logic nop;
    ifd_dec_type dec;
  } ifd_state_type;

  ifd_state_type st_q;
  ifd_state_type st_d;
  ifd_dec_type nd;
  logic last_cyc;
  logic end_cyc;
  logic fixed_redirect;
  logic indirect_extra;
  logic skip_taken;
  logic [1:0] next_total;

  // the phase counter wraps on its own width, and the operand fields must
  // tile the word the way the slicing in decode assumes; refuse the rest
  if (PHASES != (1 << $bits(PHASE_LAST))) begin : g_bad_phases
    $error("ifd_decoder: phase counter serves four clocks only");
  end
  if ((F_LSB + F_W != B_LSB) || (D_POS != B_LSB) || (B_LSB + B_W > WORD_W)) begin : g_bad_file
    $error("ifd_decoder: file and bit fields do not tile the word");
  end
  if ((K6_W != N_POS) || (PTR_INC_N_POS != MM_W) || (K11_W > WORD_W)) begin : g_bad_lit
    $error("ifd_decoder: literal or pointer fields do not fit the word");
  end

  // cycle boundaries
  assign end_cyc = (st_q.phase == PHASE_LAST);
  assign last_cyc = (st_q.icyc == (st_q.total - ONE_CYC));
  // a new word is taken on the final clock of the final cycle; a skip found
  // true at the end of a one-cycle word holds the fetch back for its nop
  assign FETCH_REQ = end_cyc && last_cyc && !skip_taken;

  // pacing terms for the incoming word
  always_comb begin
    nd = decode(WORD_IN);
    fixed_redirect = 1'b0;
    case (nd.op)
      OP_CALL, OP_CALL_ACC: fixed_redirect = 1'b1;
      OP_RETURN, OP_RET_LIT, OP_INT_RET: fixed_redirect = 1'b1;
      OP_ABS_JUMP, OP_REL_JUMP, OP_REL_JUMP_ACC: fixed_redirect = 1'b1;
      default: fixed_redirect = 1'b0;
    endcase
    // pointer region is sampled as the word is taken
    indirect_extra = nd.file_rmw
      && (((nd.faddr == PORT0_ADDR) && PTR_IN_PROG[0])
      || ((nd.faddr == PORT1_ADDR) && PTR_IN_PROG[1]));
    next_total = ONE_CYC + {1'b0, fixed_redirect}
      + {1'b0, indirect_extra};
  end

  // skip outcome is judged at the end of the first cycle
  assign skip_taken = (st_q.dec.op == OP_SKIP) && TEST_TRUE
    && end_cyc && (st_q.icyc == 2'h0);

  // next state
  always_comb begin
    st_d = st_q;
    st_d.phase = st_q.phase + ONE_CYC;
    if (FETCH_REQ) begin
      st_d.phase = 2'h0;
      st_d.icyc = 2'h0;
      st_d.dec = nd;
      st_d.total = next_total;
      st_d.redirect = fixed_redirect;
      st_d.nop = 1'b0;
    end else if (end_cyc) begin
      st_d.icyc = st_q.icyc + ONE_CYC;
      if (skip_taken) begin
        st_d.total = st_q.total + ONE_CYC;
        st_d.redirect = 1'b1;
      end
      // the closing cycle of a redirect runs as a nop
      st_d.nop = (st_q.redirect || skip_taken)
        && ((st_q.icyc + ONE_CYC) == (st_d.total - ONE_CYC));
    end
  end

  // state register; reset loads an all-zero decode: word 0, byte class, plain op
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q.phase <= 2'h0;
      st_q.icyc <= 2'h0;
      st_q.total <= ONE_CYC;
      st_q.redirect <= 1'b0;
      st_q.nop <= 1'b0;
      st_q.dec <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign DEC = st_q.dec;
  assign PHASE = st_q.phase;
  assign CYCLE_IDX = st_q.icyc;
  assign EXEC_NOP = st_q.nop;

endmodule

// ---- common/ifd_pkg.sv ----
// ifd_pkg: constants and carrier types of the instruction format decoder.
// assumes a 14-bit program word and a four-phase instruction cycle.
package ifd_pkg;

  // word and cycle geometry
  localparam int WORD_W = 14;
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] ONE_CYC = 2'h1;

  // operand field positions
  localparam int F_LSB = 0;
  localparam int F_W = 7;
  localparam int D_POS = 7;
  localparam int B_LSB = 7;
  localparam int B_W = 3;
  localparam int K8_W = 8;
  localparam int K11_W = 11;
  localparam int K7_W = 7;
  localparam int K5_W = 5;
  localparam int K9_W = 9;
  localparam int K6_W = 6;
  localparam int N_POS = 6;
  localparam int MM_W = 2;
  localparam int PTR_INC_N_POS = 2;

  // file addresses of the two pointer access ports
  localparam logic [F_W-1:0] PORT0_ADDR = 7'h00;
  localparam logic [F_W-1:0] PORT1_ADDR = 7'h01;

  // opcode values and masks (bits marked don't-care are masked off)
  localparam logic [13:0] M_ALL = 14'h3FFF;
  localparam logic [13:0] M_HI6 = 14'h3F00;
  localparam logic [13:0] M_HI5 = 14'h3E00;
  localparam logic [13:0] M_HI4 = 14'h3C00;
  localparam logic [13:0] M_HI3 = 14'h3800;
  localparam logic [13:0] M_HI2 = 14'h3000;
  localparam logic [13:0] M_HI7 = 14'h3F80;
  localparam logic [13:0] M_HI9 = 14'h3FE0;
  localparam logic [13:0] M_HI11 = 14'h3FF8;
  localparam logic [13:0] M_HI12 = 14'h3FFC;
  localparam logic [13:0] V_CALL = 14'h2000;
  localparam logic [13:0] V_ABS_JUMP = 14'h2800;
  localparam logic [13:0] V_REL_JUMP = 14'h3200;
  localparam logic [13:0] V_RET_LIT = 14'h3400;
  localparam logic [13:0] V_LOAD_PAGE = 14'h3180;
  localparam logic [13:0] V_PTROFS = 14'h3100;
  localparam logic [13:0] V_LOAD_BANK = 14'h0020;
  localparam logic [13:0] V_PTRINC = 14'h0010;
  localparam logic [13:0] V_REL_JUMP_ACC = 14'h000B;
  localparam logic [13:0] V_CALL_ACC = 14'h000A;
  localparam logic [13:0] V_INT_RET = 14'h0009;
  localparam logic [13:0] V_RETURN = 14'h0008;
  localparam logic [13:0] V_DEC_SKIP = 14'h0B00;
  localparam logic [13:0] V_INC_SKIP = 14'h0F00;
  localparam logic [13:0] V_SKIP_CLR = 14'h1800;
  localparam logic [13:0] V_SKIP_SET = 14'h1C00;
  localparam logic [13:0] V_BITCLS = 14'h1000;
  localparam logic [13:0] V_STORE_ACC = 14'h0080;
  localparam logic [13:0] V_CLR_ACC = 14'h0100;
  localparam logic [13:0] V_ZERO = 14'h0000;
  localparam logic [13:0] V_HI_BYTE0 = 14'h3500;
  localparam logic [13:0] V_HI_BYTE1 = 14'h3600;
  localparam logic [13:0] V_HI_BYTE2 = 14'h3700;
  localparam logic [13:0] V_HI_BYTE3 = 14'h3B00;
  localparam logic [13:0] V_HI_BYTE4 = 14'h3D00;

  typedef enum logic [1:0] {
    CLS_BYTE = 2'b00,
    CLS_BIT = 2'b01,
    CLS_LITCTL = 2'b10
  } ifd_cls_type;

  typedef enum logic [3:0] {
    OP_PLAIN = 4'b0000,
    OP_CALL = 4'b0001,
    OP_CALL_ACC = 4'b0010,
    OP_RETURN = 4'b0011,
    OP_RET_LIT = 4'b0100,
    OP_INT_RET = 4'b0101,
    OP_ABS_JUMP = 4'b0110,
    OP_REL_JUMP = 4'b0111,
    OP_REL_JUMP_ACC = 4'b1000,
    OP_SKIP = 4'b1001,
    OP_LOAD_PAGE = 4'b1010,
    OP_LOAD_BANK = 4'b1011,
    OP_PTROFS = 4'b1100,
    OP_PTRINC = 4'b1101,
    OP_ONLY = 4'b1110
  } ifd_op_type;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    ifd_cls_type cls;
    ifd_op_type op;
    logic file_rmw;
    logic dest_file;
    logic [F_W-1:0] faddr;
    logic [B_W-1:0] bitno;
    logic [K8_W-1:0] k8;
    logic [K11_W-1:0] k11;
    logic [K7_W-1:0] k7;
    logic [K5_W-1:0] k5;
    logic [K9_W-1:0] k9;
    logic [K6_W-1:0] k6;
    logic ptr_sel;
    logic [MM_W-1:0] mode;
  } ifd_dec_type;

endpackage

// ---- test/ifd_decoder_monitor.sv ----
// ifd_decoder_monitor: port-level pacing and field checks for the decoder.
// assumes it is bound into ifd_decoder; one clock, async active-low reset.
`timescale 1ns/10ps
module ifd_decoder_monitor
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // fetch side and datapath status
  input wire logic [ifd_pkg::WORD_W-1:0] WORD_IN,
  input wire logic FETCH_REQ,
  input wire logic TEST_TRUE,
  input wire logic [1:0] PTR_IN_PROG,
  // decoded instruction and pacing
  input wire ifd_pkg::ifd_dec_type DEC,
  input wire logic [1:0] PHASE,
  input wire logic [1:0] CYCLE_IDX,
  input wire logic EXEC_NOP
);
  // all checks on the core clock, quiet while reset is low
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_fetch_phase: assert property (FETCH_REQ |-> PHASE == 2'h3)
    else $error("fetch outside phase 3");
  a_fetch_load: assert property (
    FETCH_REQ |=> PHASE == 2'h0 && CYCLE_IDX == 2'h0 && DEC.word == $past(WORD_IN))
    else $error("fetched word not loaded");
  a_dec_hold: assert property (!FETCH_REQ |=> $stable(DEC))
    else $error("decode changed mid instruction");
  a_call_two: assert property (
    FETCH_REQ && WORD_IN[13:12] == 2'h2 |=> !FETCH_REQ [*7] ##1 FETCH_REQ)
    else $error("call or jump length");
  a_ret_two: assert property (
    FETCH_REQ && (WORD_IN[13:2] == 12'h002 || WORD_IN[13:8] == 6'h34 || WORD_IN[13:9] == 5'h19)
    |=> !FETCH_REQ [*7] ##1 FETCH_REQ) else $error("return or branch length");
  a_plain_one: assert property (
    FETCH_REQ && (WORD_IN[13:8] == 6'h30 || WORD_IN[13:5] == 9'h001)
    |=> !FETCH_REQ [*3] ##1 FETCH_REQ) else $error("literal length");
  a_indirect_extra: assert property (
    FETCH_REQ && WORD_IN[13:8] == 6'h07 && WORD_IN[6:0] == 7'h00 && PTR_IN_PROG[0]
    |=> !FETCH_REQ [*7] ##1 FETCH_REQ) else $error("indirect extra cycle");
  a_skip_taken: assert property (
    FETCH_REQ && WORD_IN[13:11] == 3'h3 && PTR_IN_PROG == 2'h0 ##4 TEST_TRUE
    |=> !FETCH_REQ [*3] ##1 FETCH_REQ && EXEC_NOP) else $error("taken skip length");
  a_nop_last: assert property (
    $rose(EXEC_NOP) |-> PHASE == 2'h0 && CYCLE_IDX != 2'h0 ##3 FETCH_REQ ##1 !EXEC_NOP)
    else $error("nop cycle misplaced");
  a_byte_dest: assert property (
    FETCH_REQ && WORD_IN[13:12] == 2'h0 && WORD_IN[11:8] > 4'h1
    |=> DEC.dest_file == $past(WORD_IN[7]) && DEC.faddr == $past(WORD_IN[6:0]))
    else $error("byte operand fields");
endmodule

bind ifd_decoder ifd_decoder_monitor i_mon (.CLK(CLK), .RESET_N(RESET_N), .WORD_IN(WORD_IN),
  .FETCH_REQ(FETCH_REQ), .TEST_TRUE(TEST_TRUE), .PTR_IN_PROG(PTR_IN_PROG), .DEC(DEC),
  .PHASE(PHASE), .CYCLE_IDX(CYCLE_IDX), .EXEC_NOP(EXEC_NOP));

// ---- test/ifd_prog_mem.sv ----
// ifd_prog_mem: program memory model, one word handed over per fetch.
// assumes the bench loads the image and resets it together with the core.
`timescale 1ns/10ps
module ifd_prog_mem
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // program image and fetch side
  input wire logic [31:0][ifd_pkg::WORD_W-1:0] image,
  input wire logic fetch,
  output logic [ifd_pkg::WORD_W-1:0] word
);
  logic [4:0] addr_q;

  // step on each taken word; the core has no stall, so a word is always shown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 5'h00;
    end else if (fetch) begin
      addr_q <= addr_q + 5'h01;
    end
  end

  assign word = image[addr_q];
endmodule

// ---- test/ifd_decoder_tb_top.sv ----
// ifd_decoder_tb_top: table-driven decode and pacing checks, then reset.
// assumes ifd_decoder and ifd_prog_mem; inputs driven at the rising edge.
`timescale 1ns/10ps
module ifd_decoder_tb_top;
  import ifd_pkg::*;
  typedef struct packed {
    logic [13:0] w;
    logic [1:0] ptr;
    logic tt;
    logic [1:0] cls;
    logic [1:0] cyc;
    logic nop;
    logic [3:0] kind;
  } ifd_row_type;
  localparam int NR = 24;
  logic CLK;
  logic RESET_N = 1'b0;
  logic TEST_TRUE = 1'b0;
  logic [1:0] PTR_IN_PROG = 2'h0;
  logic [13:0] WORD_IN;
  logic FETCH_REQ;
  logic EXEC_NOP;
  logic [1:0] PHASE;
  logic [1:0] CYCLE_IDX;
  ifd_dec_type DEC;
  logic [31:0][13:0] image;
  ifd_row_type rows [NR];
  int num_errors = 0;
  int checks_done = 0;

  ifd_decoder i_dut (.CLK(CLK), .RESET_N(RESET_N), .WORD_IN(WORD_IN), .FETCH_REQ(FETCH_REQ),
    .TEST_TRUE(TEST_TRUE), .PTR_IN_PROG(PTR_IN_PROG), .DEC(DEC), .PHASE(PHASE),
    .CYCLE_IDX(CYCLE_IDX), .EXEC_NOP(EXEC_NOP));
  ifd_prog_mem i_mem (.clk(CLK), .rst_n(RESET_N), .image(image), .fetch(FETCH_REQ),
    .word(WORD_IN));

  // 100 MHz core clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // operand bits of the format picked by kind; 9 folds all fields to one bit
  function automatic logic [15:0] field_of(input ifd_dec_type d, input logic [3:0] k);
    case (k)
      4'h0: field_of = 16'({d.dest_file, d.faddr});
      4'h1: field_of = 16'({d.bitno, d.faddr});
      4'h2: field_of = 16'(d.k8);
      4'h3: field_of = 16'(d.k11);
      4'h4: field_of = 16'(d.k7);
      4'h5: field_of = 16'(d.k5);
      4'h6: field_of = 16'(d.k9);
      4'h7: field_of = 16'({d.ptr_sel, d.k6});
      4'h8: field_of = 16'({d.ptr_sel, d.mode});
      4'h9: field_of = 16'(|{d.dest_file, d.faddr, d.bitno, d.k8, d.k11, d.k7, d.k5, d.k9,
                             d.k6, d.ptr_sel, d.mode});
      default: field_of = 16'h0000;
    endcase
  endfunction

  // expected operand: the low bits of the word, as wide as the format says
  function automatic logic [15:0] expect_of(input logic [13:0] w, input logic [3:0] k);
    int wd;
    case (k)
      4'h0, 4'h2: wd = 8;
      4'h1: wd = 10;
      4'h3: wd = 11;
      4'h4, 4'h7: wd = 7;
      4'h5: wd = 5;
      4'h6: wd = 9;
      4'h8: wd = 3;
      default: wd = 0;
    endcase
    expect_of = 16'(w) & ((16'h0001 << wd) - 16'h0001);
  endfunction

  // count negedges up to the one showing the fetch, then step onto the take edge
  task automatic wait_fetch(output int n, output logic nop);
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (FETCH_REQ !== 1'b1 && n < 40);
    nop = EXEC_NOP;
    @(posedge CLK);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog: the whole table runs in under two hundred clocks
  initial begin
    repeat (3000) @(posedge CLK);
    num_errors++;
    finish_test();
  end

  initial begin
    int n;
    logic nop;
    // word, pointer region, skip result, class, cycles, nop, operand kind
    rows = '{'{14'h07FF, 0, 0, 0, 1, 0, 0}, '{14'h0700, 1, 0, 0, 2, 0, 0},
      '{14'h0780, 2, 0, 0, 1, 0, 0}, '{14'h0081, 2, 0, 0, 2, 0, 0},
      '{14'h13D5, 0, 0, 1, 1, 0, 1}, '{14'h1912, 0, 0, 1, 1, 0, 1},
      '{14'h1FFF, 0, 1, 1, 2, 1, 1}, '{14'h0B20, 0, 1, 0, 2, 1, 0},
      '{14'h0F80, 1, 1, 0, 3, 1, 0}, '{14'h27FF, 0, 0, 2, 2, 1, 3},
      '{14'h2801, 0, 0, 2, 2, 1, 3}, '{14'h33FF, 0, 0, 2, 2, 1, 6},
      '{14'h000B, 0, 0, 2, 2, 1, 9}, '{14'h000A, 0, 0, 2, 2, 1, 9},
      '{14'h0008, 0, 0, 2, 2, 1, 9}, '{14'h0009, 0, 0, 2, 2, 1, 9},
      '{14'h34A5, 0, 0, 2, 2, 1, 2}, '{14'h31FF, 0, 0, 2, 1, 0, 4},
      '{14'h003F, 0, 0, 2, 1, 0, 5}, '{14'h316A, 0, 0, 2, 1, 0, 7},
      '{14'h0016, 0, 0, 2, 1, 0, 8}, '{14'h30C3, 0, 0, 2, 1, 0, 2},
      '{14'h0100, 0, 0, 0, 1, 0, 9}, '{14'h0103, 0, 0, 0, 1, 0, 9}};
    image = '0;
    for (int i = 0; i < NR; i++) begin
      image[i] = rows[i].w;
    end
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    wait_fetch(n, nop);
    check("first fetch", 16'(n), 16'h0004);
    // table loop: pointer region for the next word is set one take edge early
    for (int i = 0; i < NR; i++) begin
      TEST_TRUE <= rows[i].tt;
      PTR_IN_PROG <= (i + 1 < NR) ? rows[i + 1].ptr : 2'h0;
      @(negedge CLK);
      check("word", 16'(DEC.word), 16'(rows[i].w));
      check("class", 16'(DEC.cls), 16'(rows[i].cls));
      check("rmw", 16'(DEC.file_rmw), 16'(rows[i].cls != 2'h2 && rows[i].kind != 4'h9));
      check("operand", field_of(DEC, rows[i].kind), expect_of(rows[i].w, rows[i].kind));
      wait_fetch(n, nop);
      check("clocks", 16'(n + 1), 16'(4 * rows[i].cyc));
      check("last nop", 16'(nop), 16'(rows[i].nop));
    end
    // reset in mid-instruction, then a clean restart from the first word
    repeat (6) @(posedge CLK);
    RESET_N <= 1'b0;
    @(negedge CLK);
    check("reset", {PHASE, CYCLE_IDX, EXEC_NOP, FETCH_REQ, 9'h000, |DEC}, 16'h0000);
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    wait_fetch(n, nop);
    check("restart", 16'(n), 16'h0004);
    @(negedge CLK);
    check("restart word", 16'(DEC.word), 16'(rows[0].w));
    finish_test();
  end
endmodule
